// *** hdl/dps_pkg.sv ***
// Constants, latch layouts and bus map of the dual synthesizer serial block
package dps_pkg;
  // Serial word geometry
  localparam int WORD_W = 23;
  localparam int R_W = 14;
  localparam int A_W = 7;
  localparam int M_W = 11;
  // Field positions inside the shifted word
  localparam int DEST_LSB = 0;
  localparam int R_LSB = 2;
  localparam int POL_BIT = 16;
  localparam int MON_BIT = 17;
  localparam int A_LSB = 2;
  localparam int M_LSB = 9;
  localparam int MOD_BIT = 20;
  // Smallest legal ratios; smaller loads are raised to these
  localparam logic [R_W-1:0] R_MIN = 14'h0005;
  localparam logic [M_W-1:0] M_MIN = 11'h005;
  // Prescaler base moduli for each section
  localparam int RF_PRE_LO = 64;
  localparam int RF_PRE_HI = 128;
  localparam int IF_PRE_LO = 16;
  localparam int IF_PRE_HI = 32;
  // Lock detect: tolerated phase error width in core cycles
  localparam logic [7:0] LOCK_TOL = 8'h03;
  localparam logic [7:0] LOCK_WIN_RST = 8'h04;
  localparam int N_SYNC = 8;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_SHIFT = 8'h08;
  localparam logic [7:0] OFS_IF_REF = 8'h0C;
  localparam logic [7:0] OFS_IF_PROG = 8'h10;
  localparam logic [7:0] OFS_RF_REF = 8'h14;
  localparam logic [7:0] OFS_RF_PROG = 8'h18;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Destination latch chosen by the two control bits
  typedef enum logic [1:0] {DPS_IF_REF, DPS_IF_PROG, DPS_RF_REF, DPS_RF_PROG} dps_dest_e;

  // Reference counter latch
  typedef struct packed {
    logic mon_sel;
    logic polarity;
    logic [R_W-1:0] ratio;
  } dps_ref_s;

  // Programmable counter latch
  typedef struct packed {
    logic mod_sel;
    logic [M_W-1:0] main;
    logic [A_W-1:0] swallow;
  } dps_prog_s;

  localparam dps_ref_s REF_RST = '{mon_sel: 1'b0, polarity: 1'b0, ratio: R_MIN};
  localparam dps_prog_s PROG_RST = '{mod_sel: 1'b0, main: M_MIN, swallow: 7'h00};
endpackage

// *** hdl/dps_section.sv ***
// One synthesizer section: dividers, pulse swallow, phase detector, pump, lock
module dps_section #(
  parameter int PRE_LO = 64,
  parameter int PRE_HI = 128
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ena,
  input wire dps_pkg::dps_ref_s ref_latch,
  input wire dps_pkg::dps_prog_s prog_latch,
  input wire logic ref_edge,
  input wire logic pre_edge,
  input wire logic [7:0] lock_win,
  output logic cp_out,
  output logic cp_oe,
  output logic lock,
  output logic ref_mon
);
  logic [13:0] ref_cnt;
  logic [13:0] r_eff;
  logic [10:0] m_eff;
  logic [10:0] main_cnt;
  logic [6:0] swal_cnt;
  logic [7:0] pre_cnt;
  logic [7:0] pre_top;
  logic [7:0] err_cnt;
  logic [7:0] good_cnt;
  logic ref_pulse;
  logic div_pulse;
  logic up;
  logic dn;
  logic next_up;
  logic next_dn;

  assign r_eff = (ref_latch.ratio < dps_pkg::R_MIN) ? dps_pkg::R_MIN : ref_latch.ratio;
  assign m_eff = (prog_latch.main < dps_pkg::M_MIN) ? dps_pkg::M_MIN : prog_latch.main;
  // modulus select, one extra count while swallowing
  assign pre_top = (prog_latch.mod_sel ? 8'(PRE_HI) : 8'(PRE_LO)) - ((swal_cnt != 7'h00) ? 8'h00 : 8'h01);

  always_ff @(posedge clk) begin
    if (!rstn || !ena) begin
      ref_cnt <= '0;
      ref_pulse <= 1'b0;
    end else begin
      ref_pulse <= 1'b0;
      if (ref_edge) begin
        if (ref_cnt >= r_eff - 14'h0001) begin
          ref_cnt <= '0;
          ref_pulse <= 1'b1;
        end else begin
          ref_cnt <= ref_cnt + 14'h0001;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn || !ena) begin
      pre_cnt <= '0;
      main_cnt <= '0;
      swal_cnt <= '0;
      div_pulse <= 1'b0;
    end else begin
      div_pulse <= 1'b0;
      if (pre_edge) begin
        if (pre_cnt >= pre_top) begin
          pre_cnt <= '0;
          if (main_cnt >= m_eff - 11'h001) begin
            main_cnt <= '0;
            swal_cnt <= prog_latch.swallow;
            div_pulse <= 1'b1;
          end else begin
            main_cnt <= main_cnt + 11'h001;
            if (swal_cnt != 7'h00) begin
              swal_cnt <= swal_cnt - 7'h01;
            end
          end
        end else begin
          pre_cnt <= pre_cnt + 8'h01;
        end
      end
    end
  end

  // Phase-frequency detector, both sides clear together
  always_comb begin
    next_up = up | ref_pulse;
    next_dn = dn | div_pulse;
    if (next_up && next_dn) begin
      next_up = 1'b0;
      next_dn = 1'b0;
    end
  end

  // Detector state and lock qualification by error width
  always_ff @(posedge clk) begin
    if (!rstn || !ena) begin
      up <= 1'b0;
      dn <= 1'b0;
      err_cnt <= '0;
      good_cnt <= '0;
      lock <= 1'b0;
      ref_mon <= 1'b0;
    end else begin
      up <= next_up;
      dn <= next_dn;
      if (ref_pulse) begin
        ref_mon <= ~ref_mon;
      end
      if (up || dn) begin
        err_cnt <= (err_cnt == 8'hFF) ? err_cnt : err_cnt + 8'h01;
      end else begin
        err_cnt <= '0;
      end
      if (err_cnt > dps_pkg::LOCK_TOL) begin
        good_cnt <= '0;
      end else if ((up || dn) && !next_up && !next_dn && good_cnt != 8'hFF) begin
        good_cnt <= good_cnt + 8'h01;
      end
      lock <= (good_cnt >= lock_win) && (err_cnt <= dps_pkg::LOCK_TOL);
    end
  end

  // polarity swaps pump direction; idle pump when saving
  always_ff @(posedge clk) begin
    if (!rstn || !ena) begin
      cp_out <= 1'b0;
      cp_oe <= 1'b0;
    end else begin
      cp_out <= ref_latch.polarity ? dn : up;
      cp_oe <= up ^ dn;
    end
  end
endmodule // dps_section

// *** hdl/dps_top.sv ***
// Serial load, latches, both synthesizer sections and register slave
// Operation
// - 23-bit shift register takes one data bit per serial clock rising edge.
// - While load strobe is high, shifted word goes to the latch it selects.
// - Two control bits pick IF ref, IF prog, RF ref or RF prog latch.
// - Reference divider is a 14-bit value, ratio 5 to 16383.
// - Swallow counter is binary 7-bit, 0 to 127.
// - Main programmable counter is binary 11-bit, 5 to 2047.
// - RF prescaler modulus selectable as 64/65 or 128/129.
// - IF prescaler modulus selectable as 16/17 or 32/33.
// - Monitor pin shows phase monitor when select high, lock detect when low.
// - Each section has its own power-save pin: high normal, low saving.
// - Polarity bit inverts the phase detector driving that charge pump.
// - Losing RF supply clears RF latches and shift register.
module dps_top (
  input wire logic CORE_CLK,
  input wire logic RSTN,
  input wire logic SERIAL_CLK,
  input wire logic SERIAL_DATA,
  input wire logic LOAD_STROBE,
  input wire logic IF_POWER_SAVE_IN,
  input wire logic RF_POWER_SAVE_IN,
  input wire logic RF_SUPPLY_OK,
  input wire logic REFERENCE_OSC_IN,
  input wire logic IF_PRESCALER_IN,
  input wire logic RF_PRESCALER_IN,
  output logic IF_PUMP_OUT,
  output logic IF_PUMP_OE,
  output logic RF_PUMP_OUT,
  output logic RF_PUMP_OE,
  output logic SHARED_MONITOR_PIN,
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);
  logic [dps_pkg::N_SYNC-1:0] pins;
  logic [dps_pkg::N_SYNC-1:0] sync1;
  logic [dps_pkg::N_SYNC-1:0] sync2;
  logic [dps_pkg::N_SYNC-1:0] sync3;
  logic [dps_pkg::N_SYNC-1:0] rise;
  logic [dps_pkg::WORD_W-1:0] shift_word;
  logic [dps_pkg::WORD_W-1:0] word_zext;
  dps_pkg::dps_ref_s if_ref;
  dps_pkg::dps_ref_s rf_ref;
  dps_pkg::dps_prog_s if_prog;
  dps_pkg::dps_prog_s rf_prog;
  dps_pkg::dps_ref_s word_ref;
  dps_pkg::dps_prog_s word_prog;
  dps_pkg::dps_dest_e dest;
  logic [7:0] lock_win;
  logic sclk_rise;
  logic data_s;
  logic strobe_s;
  logic if_ena;
  logic rf_ena;
  logic supply_s;
  logic if_lock;
  logic rf_lock;
  logic if_mon;
  logic rf_mon;
  logic aw_hold;
  logic w_hold;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic [31:0] next_rdata;
  logic next_rerr;

  // Pins from outside the core clock domain
  assign pins = {RF_SUPPLY_OK, RF_PRESCALER_IN, IF_PRESCALER_IN, REFERENCE_OSC_IN,
                 RF_POWER_SAVE_IN, IF_POWER_SAVE_IN, LOAD_STROBE, SERIAL_CLK};

  // Two-stage synchroniser plus an edge stage, one per pin
  genvar gi;
  generate
    for (gi = 0; gi < dps_pkg::N_SYNC; gi++) begin : g_sync
      always_ff @(posedge CORE_CLK) begin
        if (!RSTN) begin
          sync1[gi] <= 1'b0;
          sync2[gi] <= 1'b0;
          sync3[gi] <= 1'b0;
        end else begin
          sync1[gi] <= pins[gi];
          sync2[gi] <= sync1[gi];
          sync3[gi] <= sync2[gi];
        end
      end
      assign rise[gi] = sync2[gi] & ~sync3[gi];
    end
  endgenerate

  // Serial data rides its own synchroniser, aligned with the clock pin
  logic data_m;
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      data_m <= 1'b0;
      data_s <= 1'b0;
    end else begin
      data_m <= SERIAL_DATA;
      data_s <= data_m;
    end
  end

  assign sclk_rise = rise[0];
  assign strobe_s = sync2[1];
  assign if_ena = sync2[2];
  assign rf_ena = sync2[3] & supply_s;
  assign supply_s = sync2[7];

  // shift on serial clock rising edge
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      shift_word <= '0;
    // shift register lost with RF supply
    end else if (!supply_s) begin
      shift_word <= '0;
    end else if (sclk_rise) begin
      shift_word <= {shift_word[dps_pkg::WORD_W-2:0], data_s};
    end
  end

  // destination and field views of the shifted word
  assign word_zext = shift_word;
  assign dest = dps_pkg::dps_dest_e'(word_zext[dps_pkg::DEST_LSB +: 2]);
  assign word_ref = '{mon_sel: word_zext[dps_pkg::MON_BIT], polarity: word_zext[dps_pkg::POL_BIT],
                      ratio: word_zext[dps_pkg::R_LSB +: dps_pkg::R_W]};
  assign word_prog = '{mod_sel: word_zext[dps_pkg::MOD_BIT], main: word_zext[dps_pkg::M_LSB +: dps_pkg::M_W],
                       swallow: word_zext[dps_pkg::A_LSB +: dps_pkg::A_W]};

  // IF latches follow the word while strobe is high
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      if_ref <= dps_pkg::REF_RST;
      if_prog <= dps_pkg::PROG_RST;
    end else if (strobe_s) begin
      case (dest)
        dps_pkg::DPS_IF_REF: if_ref <= word_ref;
        dps_pkg::DPS_IF_PROG: if_prog <= word_prog;
        default: ;
      endcase
    end
  end

  // RF latches follow the word while strobe is high
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      rf_ref <= dps_pkg::REF_RST;
      rf_prog <= dps_pkg::PROG_RST;
    end else if (!supply_s) begin
      rf_ref <= dps_pkg::REF_RST;
      rf_prog <= dps_pkg::PROG_RST;
    end else if (strobe_s) begin
      case (dest)
        dps_pkg::DPS_RF_REF: rf_ref <= word_ref;
        dps_pkg::DPS_RF_PROG: rf_prog <= word_prog;
        default: ;
      endcase
    end
  end

  // IF section: 16/17 or 32/33 prescaler
  dps_section #(
    .PRE_LO(dps_pkg::IF_PRE_LO),
    .PRE_HI(dps_pkg::IF_PRE_HI)
  ) u_if (
    .clk(CORE_CLK),
    .rstn(RSTN),
    .ena(if_ena),
    .ref_latch(if_ref),
    .prog_latch(if_prog),
    .ref_edge(rise[4]),
    .pre_edge(rise[5]),
    .lock_win(lock_win),
    .cp_out(IF_PUMP_OUT),
    .cp_oe(IF_PUMP_OE),
    .lock(if_lock),
    .ref_mon(if_mon)
  );

  // RF section: 64/65 or 128/129 prescaler
  dps_section #(
    .PRE_LO(dps_pkg::RF_PRE_LO),
    .PRE_HI(dps_pkg::RF_PRE_HI)
  ) u_rf (
    .clk(CORE_CLK),
    .rstn(RSTN),
    .ena(rf_ena),
    .ref_latch(rf_ref),
    .prog_latch(rf_prog),
    .ref_edge(rise[4]),
    .pre_edge(rise[6]),
    .lock_win(lock_win),
    .cp_out(RF_PUMP_OUT),
    .cp_oe(RF_PUMP_OE),
    .lock(rf_lock),
    .ref_mon(rf_mon)
  );

  // monitor pin: phase monitor or combined lock detect
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      SHARED_MONITOR_PIN <= 1'b0;
    end else if (rf_ref.mon_sel) begin
      SHARED_MONITOR_PIN <= rf_mon;
    end else begin
      SHARED_MONITOR_PIN <= if_lock & rf_lock;
    end
  end

  // Write address and data taken in either order, one write at a time
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY <= 1'b0;
    end else begin
      S_AXI_AWREADY <= !aw_hold && !(S_AXI_AWVALID && S_AXI_AWREADY) && !S_AXI_BVALID;
      S_AXI_WREADY <= !w_hold && !(S_AXI_WVALID && S_AXI_WREADY) && !S_AXI_BVALID;
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_hold <= 1'b1;
        aw_addr <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_hold <= 1'b1;
        w_data <= S_AXI_WDATA;
        w_strb <= S_AXI_WSTRB;
      end
      if (aw_hold && w_hold) begin
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
      end
    end
  end

  // Write response and control register; only the control word is writable
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= dps_pkg::RESP_OKAY;
      lock_win <= dps_pkg::LOCK_WIN_RST;
    end else if (aw_hold && w_hold) begin
      S_AXI_BVALID <= 1'b1;
      if (aw_addr[7:2] == dps_pkg::OFS_CTRL[7:2]) begin
        S_AXI_BRESP <= dps_pkg::RESP_OKAY;
        if (w_strb[0]) begin
          lock_win <= w_data[7:0];
        end
      end else begin
        S_AXI_BRESP <= dps_pkg::RESP_SLVERR;
      end
    end else if (S_AXI_BVALID && S_AXI_BREADY) begin
      S_AXI_BVALID <= 1'b0;
    end
  end

  // Read decode
  always_comb begin
    next_rdata = 32'h00000000;
    next_rerr = 1'b0;
    case (S_AXI_ARADDR[7:2])
      dps_pkg::OFS_CTRL[7:2]: next_rdata = {24'h000000, lock_win};
      dps_pkg::OFS_STATUS[7:2]: next_rdata = {25'h0000000, supply_s, strobe_s, rf_ena, if_ena,
                                              rf_lock, if_lock, SHARED_MONITOR_PIN};
      dps_pkg::OFS_SHIFT[7:2]: next_rdata = {9'h000, shift_word};
      dps_pkg::OFS_IF_REF[7:2]: next_rdata = {16'h0000, if_ref};
      dps_pkg::OFS_IF_PROG[7:2]: next_rdata = {13'h0000, if_prog};
      dps_pkg::OFS_RF_REF[7:2]: next_rdata = {16'h0000, rf_ref};
      dps_pkg::OFS_RF_PROG[7:2]: next_rdata = {13'h0000, rf_prog};
      default: next_rerr = 1'b1;
    endcase
  end

  // Read channel, one read at a time
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= '0;
      S_AXI_RRESP <= dps_pkg::RESP_OKAY;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA <= next_rdata;
      S_AXI_RRESP <= next_rerr ? dps_pkg::RESP_SLVERR : dps_pkg::RESP_OKAY;
    end else if (S_AXI_RVALID) begin
      if (S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end else begin
      S_AXI_ARREADY <= 1'b1;
    end
  end
endmodule // dps_top

// *** bench/dps_host.sv ***
// Controller model that shifts serial words and pulses the load strobe
module dps_host (
  output logic sclk,
  output logic sdata,
  output logic strobe
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle link: clock stands low, strobe low
  initial begin
    sclk = 1'h0;
    sdata = 1'h1;
    strobe = 1'h0;
  end
  task automatic send_word(input logic [22:0] w, input logic commit);
    #37;
    for (int i = 22; i >= 0; i--) begin
      sdata = w[i];
      #200;
      sclk = 1'h1;
      #400;
      sclk = 1'h0;
      #200;
    end
    // Stale data is not left on the line
    sdata = ~w[0];
    if (commit) begin
      #400;
      strobe = 1'h1;
      #600;
      strobe = 1'h0;
    end
    #400;
  endtask
endmodule // dps_host

// *** bench/dps_top_sva.sv ***
// Bus and pin assertions for the dual synthesizer serial block
module dps_top_sva (
  input wire logic CORE_CLK,
  input wire logic RSTN,
  input wire logic IF_POWER_SAVE_IN,
  input wire logic RF_POWER_SAVE_IN,
  input wire logic RF_SUPPLY_OK,
  input wire logic IF_PUMP_OE,
  input wire logic RF_PUMP_OE,
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic [1:0] S_AXI_RRESP,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RSTN);
  // Handshake steps of the register bus
  sequence wr_taken;
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
  endsequence
  sequence rd_taken;
    S_AXI_ARVALID && S_AXI_ARREADY;
  endsequence
  a_reset_quiet: assert property ($rose(RSTN) |-> !S_AXI_BVALID && !S_AXI_RVALID && !IF_PUMP_OE && !RF_PUMP_OE)
    else $error("outputs active after reset");
  a_write_answer: assert property (wr_taken |-> ##[1:3] S_AXI_BVALID)
    else $error("write response missing");
  a_read_answer: assert property (rd_taken |=> S_AXI_RVALID)
    else $error("read response missing");
  a_unmapped_read: assert property (rd_taken ##0 (S_AXI_ARADDR > 8'h1B) |=>
    S_AXI_RRESP == dps_pkg::RESP_SLVERR && S_AXI_RDATA == 32'h0) else $error("unmapped read not refused");
  a_b_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write response dropped");
  a_r_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read data dropped");
  a_ar_blocked: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
    else $error("read address ready while response pending");
  a_aw_blocked: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
    else $error("write ready while response pending");
  a_if_save: assert property ((!IF_POWER_SAVE_IN) [*8] |-> !IF_PUMP_OE)
    else $error("IF pump driven in power save");
  a_rf_save: assert property ((!RF_POWER_SAVE_IN || !RF_SUPPLY_OK) [*8] |-> !RF_PUMP_OE)
    else $error("RF pump driven in power save");
endmodule // dps_top_sva

// *** bench/test_dual_pll_serial_divider_load.sv ***
// Self-checking bench for the dual synthesizer serial block
module test_dual_pll_serial_divider_load;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'h0, rstn = 1'h0, if_ps = 1'h0, rf_ps = 1'h0, supply = 1'h1;
  logic osc = 1'h0, if_pre = 1'h0, rf_pre = 1'h0, sclk, sdata, strobe;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, cnt = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic awready, wready, bvalid, arready, rvalid, rf_out, rf_oe, mon, mon_q = 1'h0;
  logic [31:0] gap = 32'h0, last_gap = 32'h0;
  logic [1:0] pump = 2'h0;
  logic [1:0] bresp, rresp, r;
  int failures = 0, n_checks = 0;
  dps_top dut (.CORE_CLK(clk), .RSTN(rstn), .SERIAL_CLK(sclk), .SERIAL_DATA(sdata), .LOAD_STROBE(strobe),
    .IF_POWER_SAVE_IN(if_ps), .RF_POWER_SAVE_IN(rf_ps), .RF_SUPPLY_OK(supply), .REFERENCE_OSC_IN(osc),
    .IF_PRESCALER_IN(if_pre), .RF_PRESCALER_IN(rf_pre), .IF_PUMP_OUT(), .IF_PUMP_OE(), .RF_PUMP_OUT(rf_out),
    .RF_PUMP_OE(rf_oe), .SHARED_MONITOR_PIN(mon), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
  dps_host host (.sclk(sclk), .sdata(sdata), .strobe(strobe));
  // Core clock
  initial forever #50 clk = ~clk;
  // Slow reference and prescaler edges
  always @(posedge clk) begin
    cnt <= cnt + 8'h01;
    osc <= cnt[4];
    if_pre <= cnt[2];
    rf_pre <= cnt[1];
  end
  // Last interval between monitor toggles in cycles, and RF pump state at each monitor toggle
  always @(posedge clk) begin
    mon_q <= mon;
    if (mon !== mon_q) begin
      gap <= 32'h1;
      last_gap <= gap;
      pump <= {rf_oe, rf_out};
    end else begin
      gap <= gap + 32'h1;
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Waits for the answer however long it takes; only the watchdog ends a hang
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (bvalid !== 1'h1);
    bready <= 1'h0;
    chk({30'h0, bresp}, {30'h0, er});
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rr);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'h0;
    end while (rvalid !== 1'h1);
    rready <= 1'h0;
    v = rdata;
    rr = rresp;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    rd(a, d, r);
    chk(d, e);
    chk({30'h0, r}, {30'h0, er});
  endtask
  // Shift a word to one latch with strobe, then read that latch back
  task automatic ld(input logic [1:0] dest, input logic [20:0] pay, input logic [31:0] e);
    host.send_word({pay, dest}, 1'h1);
    rdchk(dps_pkg::OFS_IF_REF + {4'h0, dest, 2'h0}, e, dps_pkg::RESP_OKAY);
  endtask
  task automatic close_out;
    if (failures == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Main sequence; power-save pins stay low through reset
  initial begin
    repeat (4) @(posedge clk);
    rstn <= 1'h1;
    repeat (4) @(posedge clk);
    rdchk(dps_pkg::OFS_IF_REF, 32'h5, dps_pkg::RESP_OKAY);
    rdchk(dps_pkg::OFS_RF_PROG, 32'h280, dps_pkg::RESP_OKAY);
    rdchk(dps_pkg::OFS_CTRL, 32'h4, dps_pkg::RESP_OKAY);
    if_ps <= 1'h1;
    repeat (12) @(posedge clk);
    rd(dps_pkg::OFS_STATUS, d, r);
    chk(d & 32'h78, 32'h48);
    if_ps <= 1'h0;
    rf_ps <= 1'h1;
    repeat (12) @(posedge clk);
    rd(dps_pkg::OFS_STATUS, d, r);
    chk(d & 32'h78, 32'h50);
    if_ps <= 1'h1;
    ld(2'h0, {5'h00, 1'h1, 1'h0, 14'h3FFF}, 32'hBFFF);
    ld(2'h1, {2'h0, 1'h1, 11'h7FF, 7'h7F}, 32'h7FFFF);
    ld(2'h2, {5'h00, 1'h0, 1'h1, 14'h0005}, 32'h4005);
    ld(2'h3, {2'h0, 1'h0, 11'h123, 7'h45}, 32'h91C5);
    ld(2'h3, {2'h0, 1'h1, 11'h005, 7'h00}, 32'h40280);
    ld(2'h1, {2'h0, 1'h0, 11'h400, 7'h00}, 32'h20000);
    ld(2'h2, {5'h00, 1'h1, 1'h0, 14'h0006}, 32'h8006);
    // Monitor shows the RF reference output: toggles every six reference periods of 32 cycles
    repeat (650) @(posedge clk);
    chk(last_gap, 32'hC0);
    // Reference leads the slow divider, so the pump drives high with polarity clear
    chk({30'h0, pump}, 32'h3);
    rdchk(dps_pkg::OFS_IF_REF, 32'hBFFF, dps_pkg::RESP_OKAY);
    host.send_word(23'h6B5C3C, 1'h0);
    rdchk(dps_pkg::OFS_SHIFT, 32'h6B5C3C, dps_pkg::RESP_OKAY);
    rdchk(dps_pkg::OFS_IF_REF, 32'hBFFF, dps_pkg::RESP_OKAY);
    supply <= 1'h0;
    repeat (10) @(posedge clk);
    supply <= 1'h1;
    repeat (10) @(posedge clk);
    rdchk(dps_pkg::OFS_RF_REF, 32'h5, dps_pkg::RESP_OKAY);
    rdchk(dps_pkg::OFS_RF_PROG, 32'h280, dps_pkg::RESP_OKAY);
    rdchk(dps_pkg::OFS_SHIFT, 32'h0, dps_pkg::RESP_OKAY);
    rdchk(dps_pkg::OFS_IF_PROG, 32'h20000, dps_pkg::RESP_OKAY);
    wr(dps_pkg::OFS_CTRL, 32'hFFFFFF09, dps_pkg::RESP_OKAY);
    rdchk(dps_pkg::OFS_CTRL, 32'h09, dps_pkg::RESP_OKAY);
    wr(dps_pkg::OFS_STATUS, 32'h1, dps_pkg::RESP_SLVERR);
    wr(8'h40, 32'h1, dps_pkg::RESP_SLVERR);
    rdchk(8'h40, 32'h0, dps_pkg::RESP_SLVERR);
    close_out();
  end
  // Watchdog well beyond the expected run length
  initial begin
    #2000000;
    failures++;
    close_out();
  end
endmodule // test_dual_pll_serial_divider_load

bind dps_top dps_top_sva chk_i (.CORE_CLK(CORE_CLK), .RSTN(RSTN), .IF_POWER_SAVE_IN(IF_POWER_SAVE_IN),
  .RF_POWER_SAVE_IN(RF_POWER_SAVE_IN), .RF_SUPPLY_OK(RF_SUPPLY_OK), .IF_PUMP_OE(IF_PUMP_OE),
  .RF_PUMP_OE(RF_PUMP_OE), .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
  .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP),
  .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARADDR(S_AXI_ARADDR),
  .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA),
  .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY));
